/* File: src/csl_pkg.sv */
// shared constants and types for the card select and byte lane host controller
package csl_pkg;
  // bus geometry
  localparam int DATA_W     = 16;
  localparam int LANE_W     = 8;
  localparam int ADDR_W     = 11;
  localparam int IDE_ADDR_W = 3;

  // clock and access timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int SETUP_NS      = 30;
  localparam int STROBE_NS     = 80;
  localparam int HOLD_NS       = 20;
  localparam int CNT_W         = 4;
  // least times round up to whole cycles
  localparam logic [CNT_W-1:0] SETUP_CYC  =
    CNT_W'((SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] STROBE_CYC =
    CNT_W'((STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] HOLD_CYC   =
    CNT_W'((HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] CNT_ONE    = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 4'h0;

  // pin levels
  localparam logic PIN_ASSERTED = 1'b0;
  localparam logic PIN_NEGATED  = 1'b1;
  localparam logic BYTE_EVEN    = 1'b0;
  localparam logic BYTE_ODD     = 1'b1;
  localparam logic [LANE_W-1:0] LANE_ZERO = 8'h00;
  localparam logic [ADDR_W-IDE_ADDR_W-1:0] IDE_UPPER_ZERO = 8'h00;

  // access kinds in the two card modes
  typedef enum logic [1:0] {
    KIND_WORD  = 2'h0,  // both enables, full bus
    KIND_EVEN  = 2'h1,  // low enable, even address, low lane
    KIND_ODD8  = 2'h2,  // low enable, odd address, odd byte on low lane
    KIND_ODD16 = 2'h3   // high enable only, high lane
  } csl_kind_e;

  // access sequencer, one-hot
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_SETUP  = 4'h2,
    ST_STROBE = 4'h4,
    ST_HOLD   = 4'h8
  } csl_state_e;
endpackage : csl_pkg

/* File: src/csl_sync3.sv */
// three-stage input synchroniser that updates only once the last two stages agree
`timescale 1ns/1ps
`default_nettype none
module csl_sync3 #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  // asynchronous pin level in, settled level out
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] settled
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] settled_ff;

  // stage one is read by stage two alone, to keep metastability contained
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= pinIn;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // per bit, a change counts only when stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      settled_ff <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          settled_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  assign settled = settled_ff;
endmodule : csl_sync3
`default_nettype wire

/* File: src/csl_host.sv */
// host controller driving card enables, range selects, strap and data lanes of a flash card
//
// Overview of operation
// - enables select card and give byte/word
// - dma acknowledge: selects negated, 16-bit transfers
// - card modes: strap follows upper address line
// - data line 0 even, line 8 odd
// - task file accesses byte-wide, low lane
// - IDE: only dma transfers use the full bus
// - IDE: three address lines, rest grounded
`timescale 1ns/1ps
`default_nettype none
module csl_host
  import csl_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  // configuration, same clock domain
  input  wire logic              cfgIdeMode,
  input  wire logic              cfgSlave,
  // user request
  input  wire logic              reqValid,
  input  wire logic              reqWrite,
  input  wire csl_kind_e         reqKind,
  input  wire logic              reqControlRange,
  input  wire logic              reqDma,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic              reqUpperAddr,
  input  wire logic [DATA_W-1:0] reqWdata,
  output logic                   reqReady,
  // user answer
  output logic                   rdValid,
  output logic      [DATA_W-1:0] rdData,
  // card pins; the enables double as the two range selects in IDE mode
  output logic                   lowByteCardEnableN,
  output logic                   highByteCardEnableN,
  output logic                   dmaAcknowledgeN,
  output logic      [ADDR_W-1:0] hostAddress,
  output logic                   hostReadN,
  output logic                   hostWriteN,
  output logic                   strapOut,
  output logic                   strapOe,
  input  wire logic [DATA_W-1:0] hostDataBusIn,
  output logic      [DATA_W-1:0] hostDataBusOut,
  output logic                   hostDataBusOe
);
  csl_state_e        state_ff;
  logic [CNT_W-1:0]  cnt_ff;
  logic              ready_ff;
  logic              rdValid_ff;
  logic [DATA_W-1:0] rdData_ff;
  logic              loCeN_ff;
  logic              hiCeN_ff;
  logic              dmaAckN_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic              rdN_ff;
  logic              wrN_ff;
  logic              strapOut_ff;
  logic              strapOe_ff;
  logic [DATA_W-1:0] dOut_ff;
  logic              dOe_ff;
  logic              write_ff;
  logic              hiLane_ff;
  logic              wordAcc_ff;
  logic [DATA_W-1:0] dataSettled;
  logic              accept;
  logic              lastCnt;
  logic              nxt_loCeN;
  logic              nxt_hiCeN;
  logic              nxt_dmaAckN;
  logic              nxt_hiLane;
  logic              nxt_word;
  logic [ADDR_W-1:0] nxt_addr;
  logic [DATA_W-1:0] nxt_dOut;

  // read data arrive from the pins and must be synchronised
  csl_sync3 #(.W(DATA_W)) u_dataSync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pinIn   (hostDataBusIn),
    .settled (dataSettled)
  );

  assign accept  = reqValid && ready_ff;
  assign lastCnt = (cnt_ff == CNT_ONE);

  // pin pattern for a new access, worked out from mode and kind
  always_comb begin
    nxt_loCeN   = PIN_NEGATED;
    nxt_hiCeN   = PIN_NEGATED;
    nxt_dmaAckN = PIN_NEGATED;
    nxt_hiLane  = 1'b0;
    nxt_word    = 1'b0;
    nxt_addr    = reqAddr;
    if (cfgIdeMode) begin
      nxt_addr = {IDE_UPPER_ZERO, reqAddr[IDE_ADDR_W-1:0]};
      if (reqDma) begin
        nxt_dmaAckN = PIN_ASSERTED;
        nxt_word    = 1'b1;
      end else if (reqControlRange) begin
        nxt_hiCeN = PIN_ASSERTED;
      end else begin
        nxt_loCeN = PIN_ASSERTED;
      end
    end else begin
      case (reqKind)
        KIND_WORD: begin
          nxt_loCeN = PIN_ASSERTED;
          nxt_hiCeN = PIN_ASSERTED;
          nxt_word  = 1'b1;
          nxt_addr[0] = BYTE_EVEN;
        end
        KIND_EVEN: begin
          nxt_loCeN   = PIN_ASSERTED;
          nxt_addr[0] = BYTE_EVEN;
        end
        KIND_ODD8: begin
          nxt_loCeN   = PIN_ASSERTED;
          nxt_addr[0] = BYTE_ODD;
        end
        KIND_ODD16: begin
          nxt_hiCeN  = PIN_ASSERTED;
          nxt_hiLane = 1'b1;
        end
        default: begin
          nxt_loCeN = PIN_NEGATED;
        end
      endcase
    end
    // even byte sits on lines 7..0, odd byte on lines 15..8
    if (nxt_word) begin
      nxt_dOut = reqWdata;
    end else if (nxt_hiLane) begin
      nxt_dOut = {reqWdata[LANE_W-1:0], LANE_ZERO};
    end else begin
      nxt_dOut = {LANE_ZERO, reqWdata[LANE_W-1:0]};
    end
  end

  // access sequencer: setup, strobe, hold, with one countdown
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= CNT_ZERO;
      ready_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          ready_ff <= !accept;
          if (accept) begin
            state_ff <= ST_SETUP;
            cnt_ff   <= SETUP_CYC;
          end
        end
        ST_SETUP: begin
          cnt_ff <= cnt_ff - CNT_ONE;
          if (lastCnt) begin
            state_ff <= ST_STROBE;
            cnt_ff   <= STROBE_CYC;
          end
        end
        ST_STROBE: begin
          cnt_ff <= cnt_ff - CNT_ONE;
          if (lastCnt) begin
            state_ff <= ST_HOLD;
            cnt_ff   <= HOLD_CYC;
          end
        end
        ST_HOLD: begin
          cnt_ff <= cnt_ff - CNT_ONE;
          if (lastCnt) begin
            state_ff <= ST_IDLE;
            ready_ff <= 1'b1;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          ready_ff <= 1'b0;
        end
      endcase
    end
  end

  // selects and address are held from setup through hold, then the selects negated and the address kept
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      loCeN_ff   <= PIN_NEGATED;
      hiCeN_ff   <= PIN_NEGATED;
      dmaAckN_ff <= PIN_NEGATED;
      addr_ff    <= '0;
      write_ff   <= 1'b0;
      hiLane_ff  <= 1'b0;
      wordAcc_ff <= 1'b0;
      dOut_ff    <= '0;
    end else if (accept) begin
      loCeN_ff   <= nxt_loCeN;
      hiCeN_ff   <= nxt_hiCeN;
      dmaAckN_ff <= nxt_dmaAckN;
      addr_ff    <= nxt_addr;
      write_ff   <= reqWrite;
      hiLane_ff  <= nxt_hiLane;
      wordAcc_ff <= nxt_word;
      dOut_ff    <= nxt_dOut;
    end else if (state_ff == ST_HOLD && lastCnt) begin
      loCeN_ff   <= PIN_NEGATED;
      hiCeN_ff   <= PIN_NEGATED;
      dmaAckN_ff <= PIN_NEGATED;
    end
  end

  // strobes only inside the selected window; data driven only for writes
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdN_ff <= PIN_NEGATED;
      wrN_ff <= PIN_NEGATED;
      dOe_ff <= 1'b0;
    end else begin
      if (state_ff == ST_SETUP && lastCnt) begin
        rdN_ff <= write_ff ? PIN_NEGATED : PIN_ASSERTED;
        wrN_ff <= write_ff ? PIN_ASSERTED : PIN_NEGATED;
      end else if (state_ff == ST_STROBE && lastCnt) begin
        rdN_ff <= PIN_NEGATED;
        wrN_ff <= PIN_NEGATED;
      end
      // bus released as soon as the selects drop
      if (accept) begin
        dOe_ff <= reqWrite;
      end else if (state_ff == ST_HOLD && lastCnt) begin
        dOe_ff <= 1'b0;
      end
    end
  end

  // read sample at the end of the strobe, lane picked back into the low byte
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdValid_ff <= 1'b0;
      rdData_ff  <= '0;
    end else begin
      rdValid_ff <= (state_ff == ST_STROBE) && lastCnt && !write_ff;
      if ((state_ff == ST_STROBE) && lastCnt && !write_ff) begin
        if (wordAcc_ff) begin
          rdData_ff <= dataSettled;
        end else if (hiLane_ff) begin
          rdData_ff <= {LANE_ZERO, dataSettled[DATA_W-1:LANE_W]};
        end else begin
          rdData_ff <= {LANE_ZERO, dataSettled[LANE_W-1:0]};
        end
      end
    end
  end

  // strap: card modes follow upper address, IDE grounds for master or floats for slave
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      strapOut_ff <= 1'b0;
      strapOe_ff  <= 1'b1;
    end else if (cfgIdeMode) begin
      strapOut_ff <= 1'b0;
      strapOe_ff  <= !cfgSlave; // card pull-up reads high when released
    end else begin
      strapOe_ff <= 1'b1;
      if (accept) begin
        strapOut_ff <= reqUpperAddr;
      end
    end
  end

  assign reqReady            = ready_ff;
  assign rdValid             = rdValid_ff;
  assign rdData              = rdData_ff;
  assign lowByteCardEnableN  = loCeN_ff;
  assign highByteCardEnableN = hiCeN_ff;
  assign dmaAcknowledgeN     = dmaAckN_ff;
  assign hostAddress         = addr_ff;
  assign hostReadN           = rdN_ff;
  assign hostWriteN          = wrN_ff;
  assign strapOut            = strapOut_ff;
  assign strapOe             = strapOe_ff;
  assign hostDataBusOut      = dOut_ff;
  assign hostDataBusOe       = dOe_ff;

  // helper: strobe length so far; still holds the full count at the edge that first sees the release
  logic [CNT_W-1:0] strobeLen_ff;
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      strobeLen_ff <= CNT_ZERO;
    end else if (!(rdN_ff && wrN_ff)) begin
      strobeLen_ff <= strobeLen_ff + CNT_ONE;
    end else begin
      strobeLen_ff <= CNT_ZERO;
    end
  end

  strobe_needs_select_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !(rdN_ff && wrN_ff) |-> !(loCeN_ff && hiCeN_ff && dmaAckN_ff))
    else $error("strobe without any select");
  bus_released_idle_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (loCeN_ff && hiCeN_ff && dmaAckN_ff) |-> !dOe_ff)
    else $error("data driven while card not selected");
  dma_selects_off_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !dmaAckN_ff |-> (loCeN_ff && hiCeN_ff && wordAcc_ff))
    else $error("range select active during dma acknowledge");
  odd_high_lane_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    accept && !cfgIdeMode && reqKind == KIND_ODD16 ##1 1'b1
    |-> !hiCeN_ff && loCeN_ff && hiLane_ff)
    else $error("odd byte not on high enable");
  low_addr_bit_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    accept && !cfgIdeMode && reqKind == KIND_ODD8
    |=> !loCeN_ff && hiCeN_ff && addr_ff[0] == BYTE_ODD)
    else $error("odd byte via low enable mis-encoded");
  ide_addr_ground_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    accept && cfgIdeMode |=> addr_ff[ADDR_W-1:IDE_ADDR_W] == IDE_UPPER_ZERO)
    else $error("upper address not grounded in IDE mode");
  ide_strap_role_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $stable(cfgIdeMode) && cfgIdeMode && $stable(cfgSlave)
    |=> (strapOe_ff == !$past(cfgSlave)) && !strapOut_ff)
    else $error("strap does not reflect role");
  strobe_length_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(rdN_ff && wrN_ff) |-> strobeLen_ff == STROBE_CYC)
    else $error("strobe pulse length wrong");
  low_lane_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    accept && cfgIdeMode && !reqDma |=> dOut_ff[DATA_W-1:LANE_W] == LANE_ZERO)
    else $error("task file write uses high lane");

  word_cover: cover property (@(posedge ref_clk) disable iff (!resetn)
    accept && !cfgIdeMode && reqKind == KIND_WORD);
  dma_cover: cover property (@(posedge ref_clk) disable iff (!resetn)
    accept && cfgIdeMode && reqDma);
  read_cover: cover property (@(posedge ref_clk) disable iff (!resetn) rdValid_ff && hiLane_ff);
endmodule : csl_host
`default_nettype wire

/* File: verification/csl_card_model.sv */
// behavioural flash card: lane steering, register ranges, strap pull-up
`timescale 1ns/1ps
`default_nettype none
module csl_card_model
  import csl_pkg::*;
(
  // card mode, set by the bench
  input  wire logic              ideMode,
  // pins from the host
  input  wire logic              lowEnN,
  input  wire logic              highEnN,
  input  wire logic              dmaAckN,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              rdN,
  input  wire logic              wrN,
  input  wire logic              strapOut,
  input  wire logic              strapOe,
  input  wire logic [DATA_W-1:0] hostOut,
  // card side of the bus and its role
  output logic      [DATA_W-1:0] cardOut,
  output logic                   isSlave
);
  logic [LANE_W-1:0] evenMem [256];
  logic [LANE_W-1:0] oddMem [256];
  logic [LANE_W-1:0] taskRegs [8];
  logic [LANE_W-1:0] ctlReg;
  logic [DATA_W-1:0] dmaWord;
  logic [DATA_W-1:0] lastOut = 16'h5a5a;
  logic [7:0]        idx;
  logic              sel;

  // role only matters in ide mode; an open pin reads high
  assign isSlave = ideMode & (strapOe ? strapOut : 1'b1);
  assign idx = addr[8:1];
  // ide: one range select, or dma with both negated
  assign sel = ideMode ? ((!dmaAckN && lowEnN && highEnN) || (lowEnN != highEnN))
                       : !(lowEnN && highEnN);

  // undriven lanes show the inverse of the last value so stale data cannot pass
  always @(rdN, sel, lowEnN, highEnN, dmaAckN, addr) begin
    cardOut = ~lastOut;
    if (!rdN && sel) begin
      if (ideMode && !dmaAckN) cardOut = dmaWord;
      else if (ideMode) cardOut[7:0] = lowEnN ? ctlReg : taskRegs[addr[2:0]];
      else if (!highEnN && !lowEnN) cardOut = {oddMem[idx], evenMem[idx]};
      else if (!highEnN) cardOut[15:8] = oddMem[idx];
      else cardOut[7:0] = addr[0] ? oddMem[idx] : evenMem[idx];
      lastOut = cardOut;
    end
  end

  // writes land at the end of the strobe, while the selects still stand
  always @(posedge wrN) begin
    if (sel && ideMode && !dmaAckN) dmaWord <= hostOut;
    else if (sel && ideMode && !lowEnN) taskRegs[addr[2:0]] <= hostOut[7:0];
    else if (sel && ideMode) ctlReg <= hostOut[7:0];
    else if (sel) begin
      if (!lowEnN && !addr[0]) evenMem[idx] <= hostOut[7:0];
      if (!lowEnN && addr[0]) oddMem[idx] <= hostOut[7:0];
      if (!highEnN) oddMem[idx] <= hostOut[15:8];
    end
  end
endmodule : csl_card_model
`default_nettype wire

/* File: verification/tb_csl_host.sv */
// self-checking bench for the card select and byte lane host controller
`timescale 1ns/1ps
`default_nettype none
module tb_csl_host
  import csl_pkg::*;
;
  localparam logic [1:0] EN_OF_KIND [4] = '{2'b00, 2'b01, 2'b01, 2'b10};
  logic refClk = 1'b0, resetn = 1'b0, cfgIdeMode = 1'b0, cfgSlave = 1'b0;
  logic reqValid = 1'b0, reqWrite = 1'b0, reqControlRange = 1'b0, reqDma = 1'b0;
  csl_kind_e reqKind = KIND_WORD;
  logic [ADDR_W-1:0] reqAddr = '0, hostAddress;
  logic reqUpperAddr = 1'b0;
  logic [DATA_W-1:0] reqWdata = '0, rdData, cardOut, hostDataBusOut, rd;
  logic reqReady, rdValid, lowByteCardEnableN, highByteCardEnableN, dmaAcknowledgeN;
  logic hostReadN, hostWriteN, strapOut, strapOe, hostDataBusOe, isSlave;
  int mismatches = 0, nChecks = 0;

  always #4 refClk = ~refClk;

  csl_host u_dut (.ref_clk(refClk), .resetn(resetn), .cfgIdeMode(cfgIdeMode),
    .cfgSlave(cfgSlave), .reqValid(reqValid), .reqWrite(reqWrite), .reqKind(reqKind),
    .reqControlRange(reqControlRange), .reqDma(reqDma), .reqAddr(reqAddr),
    .reqUpperAddr(reqUpperAddr), .reqWdata(reqWdata), .reqReady(reqReady),
    .rdValid(rdValid), .rdData(rdData), .lowByteCardEnableN(lowByteCardEnableN),
    .highByteCardEnableN(highByteCardEnableN), .dmaAcknowledgeN(dmaAcknowledgeN),
    .hostAddress(hostAddress), .hostReadN(hostReadN), .hostWriteN(hostWriteN),
    .strapOut(strapOut), .strapOe(strapOe), .hostDataBusIn(cardOut),
    .hostDataBusOut(hostDataBusOut), .hostDataBusOe(hostDataBusOe));

  csl_card_model u_card (.ideMode(cfgIdeMode), .lowEnN(lowByteCardEnableN),
    .highEnN(highByteCardEnableN), .dmaAckN(dmaAcknowledgeN), .addr(hostAddress),
    .rdN(hostReadN), .wrN(hostWriteN), .strapOut(strapOut), .strapOe(strapOe),
    .hostOut(hostDataBusOut), .cardOut(cardOut), .isSlave(isSlave));

  task automatic check(input logic ok, input string msg);
    nChecks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // one full access; pins are judged inside the strobe, the bus again once idle
  task automatic access(input logic ide, input logic wr, input csl_kind_e kind,
                        input logic ctl, input logic dma, input logic [ADDR_W-1:0] a,
                        input logic up, input logic [DATA_W-1:0] wd);
    logic [1:0] expEn;
    int n;
    expEn = ide ? (dma ? 2'b11 : (ctl ? 2'b10 : 2'b01)) : EN_OF_KIND[kind];
    @(posedge refClk);
    cfgIdeMode <= ide; reqWrite <= wr; reqKind <= kind; reqControlRange <= ctl;
    reqDma <= dma; reqAddr <= a; reqUpperAddr <= up; reqWdata <= wd; reqValid <= 1'b1;
    @(posedge refClk);
    reqValid <= 1'b0;
    repeat (SETUP_CYC + 1) @(posedge refClk);
    #1;
    check({lowByteCardEnableN, highByteCardEnableN} === expEn, "select pins");
    check(hostReadN === wr && hostWriteN === !wr, "strobe inside select window");
    check(dmaAcknowledgeN === !(ide && dma) && hostDataBusOe === wr, "ack or drive");
    if (ide) check(hostAddress[ADDR_W-1:IDE_ADDR_W] === IDE_UPPER_ZERO, "upper address");
    else check(strapOe === 1'b1 && strapOut === up, "strap not on address line");
    if (!ide && kind != KIND_ODD16) check(hostAddress[0] === (kind == KIND_ODD8), "byte bit");
    rd = '0;
    for (n = 0; !wr && rdValid !== 1'b1 && n < 40; n++) @(posedge refClk) #1;
    if (!wr) rd = rdData;
    for (n = 0; reqReady !== 1'b1 && n < 40; n++) @(posedge refClk) #1;
    check(n < 40 && hostDataBusOe === 1'b0 && lowByteCardEnableN === 1'b1
          && highByteCardEnableN === 1'b1, "idle bus");
  endtask : access

  // card modes: every kind written and read back through another kind
  task automatic t_card_lanes();
    access(0, 1, KIND_WORD, 0, 0, 11'h020, 1, 16'h1234);
    access(0, 0, KIND_ODD8, 0, 0, 11'h021, 0, 16'h0000);
    check(rd === 16'h0012, "odd byte on low lane");
    access(0, 0, KIND_EVEN, 0, 0, 11'h020, 1, 16'h0000);
    check(rd === 16'h0034, "even byte");
    access(0, 1, KIND_ODD16, 0, 0, 11'h020, 0, 16'h00ab);
    access(0, 0, KIND_WORD, 0, 0, 11'h020, 0, 16'h0000);
    check(rd === 16'hab34, "word after high write");
    access(0, 1, KIND_ODD8, 0, 0, 11'h021, 1, 16'h00cd);
    access(0, 0, KIND_ODD16, 0, 0, 11'h020, 0, 16'h0000);
    check(rd === 16'h00cd, "high lane odd byte");
    access(0, 1, KIND_EVEN, 0, 0, 11'h020, 0, 16'h0077);
    access(0, 0, KIND_WORD, 0, 0, 11'h020, 0, 16'h0000);
    check(rd === 16'hcd77, "word after byte writes");
  endtask : t_card_lanes

  // ide mode: task file, control range and dma word
  task automatic t_ide();
    access(1, 1, KIND_WORD, 0, 0, 11'h003, 0, 16'h775e);
    access(1, 1, KIND_WORD, 1, 0, 11'h006, 0, 16'h880c);
    access(1, 1, KIND_WORD, 0, 1, 11'h000, 0, 16'hbeef);
    access(1, 0, KIND_WORD, 0, 0, 11'h003, 0, 16'h0000);
    check(rd === 16'h005e, "task file byte");
    access(1, 0, KIND_WORD, 1, 0, 11'h006, 0, 16'h0000);
    check(rd === 16'h000c, "control byte");
    access(1, 0, KIND_WORD, 0, 1, 11'h000, 0, 16'h0000);
    check(rd === 16'hbeef, "dma word");
  endtask : t_ide

  // ide role: grounded strap gives master, released strap gives slave
  task automatic t_strap();
    @(posedge refClk);
    cfgSlave <= 1'b0;
    repeat (3) @(posedge refClk);
    #1;
    check(isSlave === 1'b0 && strapOe === 1'b1, "master strap");
    @(posedge refClk);
    cfgSlave <= 1'b1;
    repeat (3) @(posedge refClk);
    #1;
    check(isSlave === 1'b1 && strapOe === 1'b0, "slave strap");
  endtask : t_strap

  // main sequence; reset held two cycles, its contents checked before the first free edge
  initial begin
    repeat (2) @(posedge refClk);
    resetn <= 1'b1;
    #1;
    check(lowByteCardEnableN === 1'b1 && highByteCardEnableN === 1'b1 && hostReadN === 1'b1
          && hostWriteN === 1'b1 && hostDataBusOe === 1'b0 && reqReady === 1'b0
          && rdValid === 1'b0, "reset");
    repeat (2) @(posedge refClk);
    t_card_lanes();
    t_ide();
    t_strap();
    end_sim();
  end

  // a hung handshake ends the run as a failure
  initial begin
    #40000;
    mismatches++;
    end_sim();
  end
endmodule : tb_csl_host
`default_nettype wire
